/* File: hdl/ebi_page_pkg.sv */
/*
  Constants and carrier types for the external bus, interrupt pin and page port
  register slice.
  Assumes a single APB clock domain; mode and bus-cycle status arrive as levels.
*/
package ebi_page_pkg;

  // Register offsets, eight-bit registers placed as one 32-bit word each
  localparam int unsigned REG_IDX_BUS_CTRL  = 32'h0000_000E;
  localparam int unsigned REG_IDX_RESERVED  = 32'h0000_000F;
  localparam int unsigned REG_IDX_IRQ_CTRL  = 32'h0000_001E;
  localparam int unsigned REG_IDX_PAGE_DATA = 32'h0000_0032;
  localparam int unsigned REG_IDX_PAGE_DIR  = 32'h0000_0033;
  localparam int unsigned ADDR_W            = 12;

  // Field positions
  localparam int unsigned BIT_STRETCH_EN    = 0;
  localparam int unsigned BIT_IRQ_EDGE      = 7;
  localparam int unsigned BIT_IRQ_CONNECT   = 6;
  localparam int unsigned BIT_PAGE_CS_EMU   = 7;
  localparam int unsigned BIT_PAGE_CS_EXT   = 6;

  // Values after reset
  localparam logic       STRETCH_EN_RST     = 1'h1;
  localparam logic       IRQ_EDGE_RST       = 1'h0;
  localparam logic       IRQ_CONNECT_RST    = 1'h1;
  localparam logic [7:0] PAGE_DATA_RST      = 8'h00;
  localparam logic [7:0] PAGE_DIR_RST       = 8'h00;

  // Chip-select release after the bus clock falls: two pclk cycles, half a bus clock cycle
  localparam int unsigned CS_RELEASE_NS     = 25;
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned CS_RELEASE_CYC    = (CS_RELEASE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                              CS_RELEASE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_SPECIAL_SINGLE = 3'h0,
    MODE_EMUL_NARROW    = 3'h1,
    MODE_SPECIAL_TEST   = 3'h2,
    MODE_EMUL_WIDE      = 3'h3,
    MODE_NORMAL_SINGLE  = 3'h4,
    MODE_NORMAL_NARROW  = 3'h5,
    MODE_PERIPHERAL     = 3'h6,
    MODE_NORMAL_WIDE    = 3'h7
  } op_mode_type;

  // Bus cycle status from the core
  typedef struct packed {
    logic       ext_access;
    logic       emu_select;
    logic       stretched;
    logic       visible;
    logic [5:0] page;
  } bus_cycle_type;

  // Page port pin group
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
    logic [7:0] pull_up;
  } page_pins_type;

  typedef struct packed {
    logic       stretch_en;
    logic       stretch_locked;
    logic       irq_edge;
    logic       irq_edge_locked;
    logic       irq_connect;
    logic       irq_pin_d;
    logic       irq_latch;
    logic [7:0] page_data;
    logic [7:0] page_dir;
    logic       bus_clk;
    logic [1:0] phase;
    logic [3:0] cs_release;
    logic [31:0] prdata;
  } state_type;

endpackage : ebi_page_pkg

/* File: hdl/ebi_page_regs.sv */
/*
  External bus control, interrupt pin control and page port registers, with
  the bus phase clock generator and page port pin control.
  Assumes an APB master on pclk, mode and bus-cycle status from the core, and
  an external pad ring that resolves the page port pins from oe_n.
*/
// Register access over APB was decided locally.
// Operation
// - Stretch enable is write-once in normal/emulation modes, free in special modes.
// - Stretch enable clear keeps the bus phase clock free running.
// - Stretch enable set: clock high over stretched external cycles, low internal; the code lets visible internal cycles run free.
// - Single-chip modes ignore the stretch enable for the bus phase clock.
// - Expanded and peripheral modes unmap the bus control register.
// - Reserved location reads zero and ignores writes.
// - Edge select always readable; write-once except in special modes.
// - Edge select 0 means low level; 1 means falling edges only.
// - Falling edges latched in edge mode; cleared by reset or servicing.
// - Pin connect bit free to access; 0 disconnects the interrupt pin.
// - Pin connect clear disables the edge latch.
// - General I/O pin drives when direction bit is 1, else input.
// - Data read gives pin for inputs, latch for outputs.
// - Expanded/peripheral with page emulation unmaps page data and direction.
// - Input pins pulled up when the page pull enable is set.
// - Emulation: bit 7 is emulation chip select with quarter-cycle release; the code releases for half a bus clock cycle.
// - Emulation: bit 6 is external chip select with same release.
// - Emulation: bits 5:0 drive the upper six page address lines.
// - Page registers mapped without emulation; always in single chip, never peripheral.
// - Reset sets stretch enable in user modes.
`timescale 1ns/1ps

module ebi_page_regs
  import ebi_page_pkg::*;
#(
  parameter int unsigned BASE_ADDR = 0
) (
  // APB clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Mode and configuration from the core
  input  wire ebi_page_pkg::op_mode_type   op_mode,
  input  wire logic                        page_port_emulate,
  input  wire logic                        page_port_pull_en,
  // Bus cycle status
  input  wire ebi_page_pkg::bus_cycle_type bus_cycle,
  output logic                             ext_echo,
  output logic                             bus_phase_clock,
  // Interrupt pin and service
  input  wire logic                        irq_pin_n,
  input  wire logic                        irq_serviced,
  output logic                             irq_request,
  // Page port pins
  input  wire logic [7:0]                  page_pin_in,
  output ebi_page_pkg::page_pins_type      page_pins
);
  import ebi_page_pkg::*;

  state_type s_r;
  state_type s_nxt;

  logic special_mode;
  logic single_chip;
  logic expanded;
  logic ctrl_mapped;
  logic page_mapped;
  logic emu_active;
  logic wr_strobe;
  logic rd_strobe;
  logic [ADDR_W-1:0] offset;
  logic [7:0] wbyte;
  logic [7:0] page_read;
  logic fall_edge;
  logic cs_hold;

  function automatic logic hit(input logic [ADDR_W-1:0] off, input int unsigned idx);
    hit = (off[ADDR_W-1:2] == (ADDR_W-2)'(idx)) ? 1'b1 : 1'b0;
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode and mapping

  always_comb begin
    special_mode = (op_mode == MODE_SPECIAL_SINGLE) || (op_mode == MODE_SPECIAL_TEST) ||
                   (op_mode == MODE_PERIPHERAL);
    single_chip  = (op_mode == MODE_SPECIAL_SINGLE) || (op_mode == MODE_NORMAL_SINGLE);
    expanded     = !single_chip && (op_mode != MODE_PERIPHERAL);
    ctrl_mapped  = single_chip;
    page_mapped  = single_chip || (expanded && !page_port_emulate);
    emu_active   = expanded && page_port_emulate;
  end

  assign offset    = ADDR_W'(paddr - ADDR_W'(BASE_ADDR));
  assign wr_strobe = psel && penable && pwrite && pstrb[0];
  assign rd_strobe = psel && !pwrite;
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign prdata    = s_r.prdata;

  always_comb begin
    ext_echo = 1'b0;
    if (psel) begin
      if ((hit(offset, REG_IDX_BUS_CTRL) || hit(offset, REG_IDX_RESERVED)) && !ctrl_mapped) begin
        ext_echo = 1'b1;
      end
      if ((hit(offset, REG_IDX_PAGE_DATA) || hit(offset, REG_IDX_PAGE_DIR)) && !page_mapped) begin
        ext_echo = 1'b1;
      end
    end
  end

  assign page_read = (s_r.page_dir & s_r.page_data) | (~s_r.page_dir & page_pin_in);
  assign wbyte     = pwdata[7:0];
  assign fall_edge = s_r.irq_pin_d && !irq_pin_n;
  assign cs_hold   = bus_cycle.stretched && !s_r.stretch_en;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.irq_pin_d = irq_pin_n;

    if (wr_strobe && hit(offset, REG_IDX_BUS_CTRL) && ctrl_mapped) begin
      if (special_mode || !s_r.stretch_locked) begin
        s_nxt.stretch_en = wbyte[BIT_STRETCH_EN];
      end
      s_nxt.stretch_locked = 1'b1;
    end
    if (wr_strobe && hit(offset, REG_IDX_IRQ_CTRL)) begin
      if (special_mode || !s_r.irq_edge_locked) begin
        s_nxt.irq_edge = wbyte[BIT_IRQ_EDGE];
      end
      s_nxt.irq_edge_locked = 1'b1;
      s_nxt.irq_connect = wbyte[BIT_IRQ_CONNECT];
    end
    if (wr_strobe && hit(offset, REG_IDX_PAGE_DATA) && page_mapped) begin
      s_nxt.page_data = wbyte;
    end
    if (wr_strobe && hit(offset, REG_IDX_PAGE_DIR) && page_mapped) begin
      s_nxt.page_dir = wbyte;
    end

    // edge latch, set wins over service
    if (!s_nxt.irq_connect || !s_nxt.irq_edge) begin
      s_nxt.irq_latch = 1'b0;
    end else if (fall_edge) begin
      s_nxt.irq_latch = 1'b1;
    end else if (irq_serviced) begin
      s_nxt.irq_latch = 1'b0;
    end

    // Bus phase clock: four pclk phases, high in the second half
    s_nxt.phase = s_r.phase + 2'h1;
    s_nxt.bus_clk = s_r.phase[1];
    if (s_r.stretch_en && !single_chip) begin
      if (bus_cycle.ext_access && bus_cycle.stretched && s_r.bus_clk) begin
        s_nxt.phase   = s_r.phase;
        s_nxt.bus_clk = 1'b1;
      end else if (!bus_cycle.ext_access && !bus_cycle.visible) begin
        s_nxt.bus_clk = 1'b0;
      end
    end

    // release window after the falling edge
    if (s_r.bus_clk && !s_nxt.bus_clk && !cs_hold) begin
      s_nxt.cs_release = 4'(CS_RELEASE_CYC);
    end else if (s_r.cs_release != 4'h0) begin
      s_nxt.cs_release = s_r.cs_release - 4'h1;
    end

    s_nxt.prdata = 32'h0000_0000;
    if (rd_strobe && !penable) begin
      if (hit(offset, REG_IDX_BUS_CTRL) && ctrl_mapped) begin
        s_nxt.prdata[BIT_STRETCH_EN] = s_r.stretch_en;
      end else if (hit(offset, REG_IDX_IRQ_CTRL)) begin
        s_nxt.prdata[BIT_IRQ_EDGE]    = s_r.irq_edge;
        s_nxt.prdata[BIT_IRQ_CONNECT] = s_r.irq_connect;
      end else if (hit(offset, REG_IDX_PAGE_DATA) && page_mapped) begin
        s_nxt.prdata[7:0] = page_read;
      end else if (hit(offset, REG_IDX_PAGE_DIR) && page_mapped) begin
        s_nxt.prdata[7:0] = s_r.page_dir;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.stretch_en  <= STRETCH_EN_RST;
      s_r.irq_edge    <= IRQ_EDGE_RST;
      s_r.irq_connect <= IRQ_CONNECT_RST;
      s_r.irq_pin_d   <= 1'b1;
      s_r.page_data   <= PAGE_DATA_RST;
      s_r.page_dir    <= PAGE_DIR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus_phase_clock = s_r.bus_clk;

  assign irq_request = s_r.irq_connect && (s_r.irq_edge ? s_r.irq_latch : !irq_pin_n);

  always_comb begin
    page_pins.dout    = s_r.page_data;
    page_pins.oe_n    = ~s_r.page_dir;
    page_pins.pull_up = page_port_pull_en ? ~s_r.page_dir : 8'h00;
    if (emu_active) begin
      page_pins.oe_n    = 8'h00;
      page_pins.pull_up = 8'h00;
      page_pins.dout[BIT_PAGE_CS_EMU] = !(bus_cycle.ext_access && bus_cycle.emu_select &&
                                          s_r.cs_release == 4'h0);
      page_pins.dout[BIT_PAGE_CS_EXT] = !(bus_cycle.ext_access && !bus_cycle.emu_select &&
                                          s_r.cs_release == 4'h0);
      page_pins.dout[5:0] = bus_cycle.page;
    end
  end

endmodule : ebi_page_regs

/* File: sim/ebi_page_regs_chk.sv */
/* Checker for the register slice: map, page pins, bus phase clock.
   Assumes it is bound to ebi_page_regs with BASE_ADDR at 0. */
`timescale 1ns/1ps
module ebi_page_regs_chk
  import ebi_page_pkg::*;
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ADDR_W-1:0]           paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [31:0]                 prdata,
  input wire ebi_page_pkg::op_mode_type   op_mode,
  input wire logic                        page_port_emulate,
  input wire logic                        page_port_pull_en,
  input wire ebi_page_pkg::bus_cycle_type bus_cycle,
  input wire logic                        ext_echo,
  input wire logic                        bus_phase_clock,
  input wire logic [7:0]                  page_pin_in,
  input wire ebi_page_pkg::page_pins_type page_pins
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic sc = op_mode inside {MODE_SPECIAL_SINGLE, MODE_NORMAL_SINGLE};
  wire logic emu = page_port_emulate && !sc && op_mode != MODE_PERIPHERAL;
  wire logic rd = psel && !penable && !pwrite;
  ////////////////////////////////////////////////////////////////////////
  reserved_zero_a: assert property (rd && paddr == 12'h03C |=> prdata == 32'h0)
    else $error("reserved slot read nonzero");
  bus_ctrl_echo_a: assert property (psel && paddr == 12'h038 |-> ext_echo == !sc)
    else $error("bus control map wrong");
  page_map_echo_a: assert property (psel && paddr == 12'h0CC |->
      ext_echo == (op_mode == MODE_PERIPHERAL || emu))
    else $error("page port map wrong");
  dir_drive_a: assert property (sc && !page_port_emulate && psel && penable &&
      pwrite && pstrb[0] && paddr == 12'h0CC |=> page_pins.oe_n == ~$past(pwdata[7:0]))
    else $error("direction not on pins");
  pull_inputs_a: assert property (sc && $past(page_port_pull_en) == page_port_pull_en &&
      $stable(page_pins.oe_n) |->
      page_pins.pull_up == (page_pins.oe_n & {8{page_port_pull_en}}))
    else $error("pull-up mismatch");
  page_read_a: assert property (sc && !page_port_emulate && rd && paddr == 12'h0C8 |=>
      prdata[7:0] == (($past(page_pin_in) & $past(page_pins.oe_n)) |
                      ($past(page_pins.dout) & ~$past(page_pins.oe_n))))
    else $error("page data read source wrong");
  free_clock_a: assert property (sc && $rose(bus_phase_clock) |=> bus_phase_clock ##1
      !bus_phase_clock ##1 !bus_phase_clock ##1 bus_phase_clock)
    else $error("bus clock not free running");
  cs_release_a: assert property (emu && !bus_cycle.stretched &&
      $fell(bus_phase_clock) |=> page_pins.dout[7:6] == 2'h3)
    else $error("chip select not released");
  page_addr_a: assert property (emu && $past(presetn) && $stable(bus_cycle.page) |->
      page_pins.dout[5:0] == bus_cycle.page && page_pins.oe_n[5:0] == 6'h00)
    else $error("page address lines wrong");
  cover property (sc && $rose(bus_phase_clock));
  cover property (emu && $fell(bus_phase_clock));
  cover property (rd && paddr == 12'h0C8);
endmodule : ebi_page_regs_chk
bind ebi_page_regs ebi_page_regs_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .op_mode, .page_port_emulate, .page_port_pull_en, .bus_cycle,
  .ext_echo, .bus_phase_clock, .page_pin_in, .page_pins);

/* File: sim/page_pin_model.sv */
/* Far side of the page port: pads with outside drivers.
   Assumes undriven, unpulled pins float and must not read as a stable value. */
`timescale 1ns/1ps
module page_pin_model
  import ebi_page_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic [7:0]                  ext_drive,
  input  wire logic [7:0]                  ext_en,
  input  wire ebi_page_pkg::page_pins_type page_pins,
  output logic      [7:0]                  pin_level
);
  logic [7:0] float_r = 8'h55;
  always @(posedge pclk) float_r <= ~float_r;
  assign pin_level = (~page_pins.oe_n & page_pins.dout) | (page_pins.oe_n & ext_en & ext_drive)
    | (page_pins.oe_n & ~ext_en & (page_pins.pull_up | float_r));
endmodule : page_pin_model

/* File: sim/tb_top.sv */
/* Self-checking bench for ebi_page_regs.
   Assumes a zero-wait APB slave and a 100 MHz clock. */
`timescale 1ns/1ps
module tb_top;
  import ebi_page_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_echo, bus_phase_clock;
  logic page_port_emulate, page_port_pull_en, irq_pin_n, irq_serviced, irq_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        echo_q;
  logic [3:0] pstrb;
  logic [7:0] page_pin_in, ext_drive, ext_en;
  op_mode_type op_mode;
  bus_cycle_type bus_cycle;
  page_pins_type page_pins;
  int mismatches = 0, tests_run = 0, n;
  typedef struct {logic [11:0] a; logic [7:0] d, m, e;} row_type;
  row_type rows[8] = '{'{12'h038, 8'h00, 8'h01, 8'h00}, '{12'h038, 8'h01, 8'h01, 8'h00},
    '{12'h03C, 8'hFF, 8'hFF, 8'h00}, '{12'h078, 8'hC0, 8'hC0, 8'hC0},
    '{12'h078, 8'h00, 8'hC0, 8'h80}, '{12'h0C8, 8'hA5, 8'hFF, 8'h3C},
    '{12'h0CC, 8'hF0, 8'hFF, 8'hF0}, '{12'h0C8, 8'hA5, 8'hFF, 8'hAC}};
  ebi_page_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .op_mode, .page_port_emulate, .page_port_pull_en, .bus_cycle,
    .ext_echo, .bus_phase_clock, .irq_pin_n, .irq_serviced, .irq_request, .page_pin_in,
    .page_pins);
  page_pin_model i_pins (.pclk, .ext_drive, .ext_en, .page_pins, .pin_level(page_pin_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Request stands until pready is seen high at a rising edge; the answer is taken there
  task automatic apb(input logic [11:0] a, input logic wr, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q      = prdata;
    echo_q = ext_echo;
    chk("pslverr", 32'(pslverr), 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rst(input op_mode_type m, input logic e);
    @(posedge pclk);
    presetn           <= 1'b0;
    op_mode           <= m;
    page_port_emulate <= e;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  task automatic highs(input int c);
    n = 0;
    repeat (c) begin
      @(posedge pclk);
      #1 n += bus_phase_clock;
    end
  endtask : highs
  // Counts cycles with the chip select on page pin b asserted (low)
  task automatic cs_low(input int b);
    n = 0;
    repeat (16) begin
      @(posedge pclk);
      #1 n += !page_pins.dout[b];
    end
  endtask : cs_low
  task automatic results();
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #200000 mismatches++;
    results();
  end
  initial begin
    presetn           = 1'b0;
    psel              = 1'b0;
    penable           = 1'b0;
    pwrite            = 1'b0;
    paddr             = 12'h000;
    pwdata            = 32'h0000_0000;
    pstrb             = 4'hF;
    op_mode           = MODE_NORMAL_SINGLE;
    page_port_emulate = 1'b0;
    page_port_pull_en = 1'b0;
    bus_cycle         = '0;
    irq_pin_n         = 1'b1;
    irq_serviced      = 1'b0;
    ext_drive         = 8'h3C;
    ext_en            = 8'hFF;
    rst(MODE_NORMAL_SINGLE, 1'b0);
    apb(12'h038, 1'b0, 8'h00);
    chk("stretch", q & 32'h1, 32'h1);
    apb(12'h078, 1'b0, 8'h00);
    chk("irq_ctrl", q & 32'hC0, 32'h40);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 8'h00);
      chk("row", q & rows[i].m, rows[i].e);
    end
    #1 chk("oe_n", page_pins.oe_n, 8'h0F);
    @(posedge pclk);
    page_port_pull_en <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk("pull", page_pins.pull_up, 8'h0F);
    apb(12'h100, 1'b0, 8'h00);
    chk("unmapped", q, 32'h0);
    rst(MODE_SPECIAL_SINGLE, 1'b0);
    apb(12'h038, 1'b1, 8'h00);
    apb(12'h038, 1'b1, 8'h01);
    apb(12'h038, 1'b0, 8'h00);
    chk("stretch_sp1", q & 32'h1, 32'h1);
    apb(12'h038, 1'b1, 8'h00);
    apb(12'h038, 1'b0, 8'h00);
    chk("stretch_sp", q & 32'h1, 32'h0);
    apb(12'h078, 1'b1, 8'h40);
    irq_pin_n <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 chk("level", irq_request, 1'b1);
    @(posedge pclk);
    irq_pin_n <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk("level_off", irq_request, 1'b0);
    for (int k = 0; k < 2; k++) begin
      apb(12'h078, 1'b1, (k != 0) ? 8'h80 : 8'hC0);
      irq_pin_n <= 1'b0;
      @(posedge pclk);
      irq_pin_n <= 1'b1;
      repeat (3) @(posedge pclk);
      #1 chk("edge", irq_request, (k != 0) ? 1'b0 : 1'b1);
    end
    // Reconnected: the edge seen while disconnected must not have been kept
    apb(12'h078, 1'b1, 8'hC0);
    #1 chk("latch_off", irq_request, 1'b0);
    @(posedge pclk);
    irq_pin_n <= 1'b0;
    @(posedge pclk);
    irq_pin_n    <= 1'b1;
    irq_serviced <= 1'b1;
    @(posedge pclk);
    irq_serviced <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 chk("serviced", irq_request, 1'b0);
    @(posedge pclk);
    op_mode   <= MODE_SPECIAL_TEST;
    bus_cycle <= 10'h2C0;
    highs(16);
    chk("free_run", 32'(n), 32'h8);
    rst(MODE_NORMAL_WIDE, 1'b1);
    bus_cycle <= 10'h2C0;
    highs(8);
    highs(4);
    chk("stretch_hi", 32'(n), 32'h4);
    bus_cycle <= 10'h000;
    highs(8);
    highs(4);
    chk("internal_lo", 32'(n), 32'h0);
    apb(12'h0C8, 1'b0, 8'h00);
    chk("echo_read", q, 32'h0);
    chk("page_echo", echo_q, 1'b1);
    apb(12'h038, 1'b0, 8'h00);
    chk("ctrl_echo", echo_q, 1'b1);
    bus_cycle <= 10'h26A;
    highs(8);
    chk("page", 32'(page_pins.dout[5:0]), 32'h2A);
    cs_low(BIT_PAGE_CS_EXT);
    chk("ext_cs", 32'(n), 32'(16 - 4 * CS_RELEASE_CYC));
    bus_cycle <= 10'h36A;
    @(posedge pclk);
    cs_low(BIT_PAGE_CS_EMU);
    chk("emu_cs", 32'(n), 32'(16 - 4 * CS_RELEASE_CYC));
    results();
  end
endmodule : tb_top
